// file: lvadc_consts.svh
// offsets, field positions, reset values and timing counts of the led voltage converter control
// assumes inclusion by bare name from the control module only
`ifndef LVADC_CONSTS_SVH
`define LVADC_CONSTS_SVH

`define LVADC_ADDR_MON      8'h30
`define LVADC_ADDR_DLY      8'h31

`define LVADC_MON_CODE_MSB  3
`define LVADC_MON_MAN_BIT   4
`define LVADC_MON_SHDN_BIT  5
`define LVADC_MON_DONE_BIT  6
`define LVADC_DLY_NODLY_BIT 5
`define LVADC_DLY_CODE_MSB  4

`define LVADC_RST_CODE      4'h0
`define LVADC_RST_MAN       1'b0
`define LVADC_RST_SHDN      1'b0
`define LVADC_RST_DONE      1'b0
`define LVADC_RST_NODLY     1'b0
`define LVADC_RST_DCODE     5'h00

`define LVADC_STEP_US       250
`define LVADC_CLK_MHZ       100
`define LVADC_STEP_CYCLES   (`LVADC_STEP_US * `LVADC_CLK_MHZ)

`endif

// file: lvadc_ctrl.sv
// led forward voltage converter control: monitor and start delay registers, trigger and sequencing
// assumes an internal register port from the serial slave, an asynchronous flash pin and analogue converter
`timescale 1ns/100ps
`default_nettype none
`include "lvadc_consts.svh"
module lvadc_ctrl #(
   parameter int unsigned P_STEP_CYCLES = `LVADC_STEP_CYCLES
) (
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_sys_rst,
   input  wire logic [7:0]             i_reg_addr,
   input  wire logic                   i_reg_wr,
   input  wire logic [7:0]             i_reg_wdata,
   input  wire logic                   i_reg_rd,
   output logic      [7:0]             o_reg_rdata,
   input  wire logic                   i_flash_pulse,
   input  wire logic                   i_conv_ready,
   input  wire lvadc_pkg::lvadc_code_t i_led1_code,
   input  wire lvadc_pkg::lvadc_code_t i_led2_code,
   output logic                        o_conv_start,
   output logic                        o_conv_shutdown,
   output logic                        o_conv_done
);
   import lvadc_pkg::*;

   lvadc_state_e  state_q;
   lvadc_code_t   result_q;
   lvadc_dcode_t  dcode_q;
   logic          man_q;
   logic          shdn_q;
   logic          done_q;
   logic          nodly_q;
   logic          fl_s1_q, fl_s2_q, fl_s3_q;
   logic          rd_s1_q, rd_s2_q, rd_s3_q;
   lvadc_code_t   led1_s1_q, led1_s2_q;
   lvadc_code_t   led2_s1_q, led2_s2_q;
   logic          tmr_expire;

   // pin inputs: two flops, then edge detect on the second and third
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         fl_s1_q <= 1'b0;
         fl_s2_q <= 1'b0;
         fl_s3_q <= 1'b0;
         rd_s1_q <= 1'b0;
         rd_s2_q <= 1'b0;
         rd_s3_q <= 1'b0;
         led1_s1_q <= 4'h0;
         led1_s2_q <= 4'h0;
         led2_s1_q <= 4'h0;
         led2_s2_q <= 4'h0;
      end else begin
         fl_s1_q <= i_flash_pulse;
         fl_s2_q <= fl_s1_q;
         fl_s3_q <= fl_s2_q;
         rd_s1_q <= i_conv_ready;
         rd_s2_q <= rd_s1_q;
         rd_s3_q <= rd_s2_q;
         // codes ride the same two flops as ready, so they line up at finish
         led1_s1_q <= i_led1_code;
         led1_s2_q <= led1_s1_q;
         led2_s1_q <= i_led2_code;
         led2_s2_q <= led2_s1_q;
      end
   end

   logic wr_mon, wr_dly, rd_mon, flash_rise, man_req, trig, finish, shdn_now;
   assign wr_mon     = i_reg_wr && (i_reg_addr == `LVADC_ADDR_MON);
   assign wr_dly     = i_reg_wr && (i_reg_addr == `LVADC_ADDR_DLY);
   assign rd_mon     = i_reg_rd && (i_reg_addr == `LVADC_ADDR_MON);
   assign flash_rise = fl_s2_q && !fl_s3_q;
   // a write that sets manual enable is the on-demand request
   assign man_req    = wr_mon && i_reg_wdata[`LVADC_MON_MAN_BIT];
   assign shdn_now   = shdn_q || (wr_mon && i_reg_wdata[`LVADC_MON_SHDN_BIT]);
   // triggers while busy are dropped, not queued
   assign trig       = (flash_rise || man_req) && !shdn_now && (state_q == LVADC_IDLE);
   assign finish     = (state_q == LVADC_CONV) && rd_s2_q && !rd_s3_q;

   // control registers
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         man_q   <= `LVADC_RST_MAN;
         shdn_q  <= `LVADC_RST_SHDN;
         nodly_q <= `LVADC_RST_NODLY;
         dcode_q <= `LVADC_RST_DCODE;
      end else begin
         if (wr_mon) begin
            man_q  <= i_reg_wdata[`LVADC_MON_MAN_BIT];
            shdn_q <= i_reg_wdata[`LVADC_MON_SHDN_BIT];
         end
         if (wr_dly) begin
            nodly_q <= i_reg_wdata[`LVADC_DLY_NODLY_BIT];
            dcode_q <= i_reg_wdata[`LVADC_DLY_CODE_MSB:0];
         end
      end
   end

   // sequencer
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         state_q      <= LVADC_IDLE;
         o_conv_start <= 1'b0;
      end else begin
         o_conv_start <= 1'b0;
         unique case (state_q)
            LVADC_IDLE: begin
               if (trig) begin
                  if (nodly_q) begin
                     state_q      <= LVADC_CONV;
                     o_conv_start <= 1'b1;
                  end else begin
                     state_q <= LVADC_WAIT;
                  end
               end
            end
            LVADC_WAIT: begin
               if (shdn_now) begin
                  state_q <= LVADC_IDLE;
               end else if (tmr_expire) begin
                  state_q      <= LVADC_CONV;
                  o_conv_start <= 1'b1;
               end
            end
            LVADC_CONV: begin
               if (shdn_now || finish) begin
                  state_q <= LVADC_IDLE;
               end
            end
            default: state_q <= LVADC_IDLE;
         endcase
      end
   end

   lvadc_delay_timer #(
      .P_STEP_CYCLES (P_STEP_CYCLES)
   ) u_timer (
      .i_clk_sys (i_clk_sys),
      .i_sys_rst (i_sys_rst),
      .i_start   (trig && !nodly_q),
      .i_abort   (shdn_now),
      .i_steps   (dcode_q),
      .o_expire  (tmr_expire)
   );

   // done flag: finishing wins over a read clear in the same cycle
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         done_q   <= `LVADC_RST_DONE;
         result_q <= `LVADC_RST_CODE;
      end else if (finish) begin
         done_q   <= 1'b1;
         result_q <= lvadc_higher(led1_s2_q, led2_s2_q);
      end else if (trig || rd_mon) begin
         done_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_reg_rdata     <= 8'h00;
         o_conv_shutdown <= `LVADC_RST_SHDN;
         o_conv_done     <= `LVADC_RST_DONE;
      end else begin
         o_conv_shutdown <= shdn_q;
         o_conv_done     <= done_q;
         if (i_reg_rd) begin
            unique case (i_reg_addr)
               `LVADC_ADDR_MON: o_reg_rdata <= {1'b0, done_q, shdn_q, man_q, result_q};
               `LVADC_ADDR_DLY: o_reg_rdata <= {2'b00, nodly_q, dcode_q};
               default:         o_reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // helper logic for checks only
   logic [31:0]  wait_cnt_q;
   lvadc_dcode_t wait_code_q;
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         wait_cnt_q  <= 32'h0000_0000;
         wait_code_q <= 5'h00;
      end else if (trig) begin
         wait_cnt_q  <= 32'h0000_0000;
         wait_code_q <= dcode_q;
      end else if (state_q == LVADC_WAIT) begin
         wait_cnt_q <= wait_cnt_q + 32'h0000_0001;
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   property p_done_low_busy;
      (state_q != LVADC_IDLE) |-> !done_q;
   endproperty
   a_done_low_busy: assert property (p_done_low_busy) else $error("done flag high during conversion");

   property p_done_set;
      finish |=> done_q && (state_q == LVADC_IDLE) ##1 o_conv_done;
   endproperty
   a_done_set: assert property (p_done_set) else $error("done flag not set after conversion");

   property p_no_start_shdn;
      shdn_q |=> !o_conv_start && (state_q == LVADC_IDLE);
   endproperty
   a_no_start_shdn: assert property (p_no_start_shdn) else $error("conversion activity in shutdown");

   property p_wait_len;
      (state_q == LVADC_WAIT) && tmr_expire |->
         wait_cnt_q == (32'(wait_code_q) + 32'h0000_0001) * 32'(P_STEP_CYCLES);
   endproperty
   a_wait_len: assert property (p_wait_len) else $error("start delay length wrong");

   property p_same_delay;
      trig && !nodly_q |=> (state_q == LVADC_WAIT) && !o_conv_start && !done_q;
   endproperty
   a_same_delay: assert property (p_same_delay) else $error("trigger skipped the start delay");

   property p_no_delay;
      trig && nodly_q |=> o_conv_start && (state_q == LVADC_CONV) ##1 !o_conv_start;
   endproperty
   a_no_delay: assert property (p_no_delay) else $error("no-delay start not immediate");

   property p_manual;
      man_req && !shdn_now && (state_q == LVADC_IDLE) |=> (state_q != LVADC_IDLE) && !done_q;
   endproperty
   a_manual: assert property (p_manual) else $error("manual request ignored");

   property p_flash;
      $rose(fl_s2_q) && !shdn_now && (state_q == LVADC_IDLE) |=> state_q != LVADC_IDLE;
   endproperty
   a_flash: assert property (p_flash) else $error("flash pulse did not start conversion");

   property p_read_clear;
      rd_mon && !finish |=> !done_q ##1 !o_conv_done;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("read did not clear done flag");

   property p_result_max;
      finish |=> (result_q >= $past(led1_s2_q)) && (result_q >= $past(led2_s2_q)) &&
                 ((result_q == $past(led1_s2_q)) || (result_q == $past(led2_s2_q)));
   endproperty
   a_result_max: assert property (p_result_max) else $error("result not higher channel code");

   c_flash_conv:  cover property (flash_rise && trig ##[1:300] finish);
   c_manual_conv: cover property (man_req && trig && !nodly_q ##1 (state_q == LVADC_WAIT));
   c_nodly_conv:  cover property (trig && nodly_q ##[1:300] finish);
   c_read_clear:  cover property (done_q && rd_mon ##1 !done_q);
endmodule
`default_nettype wire

// file: lvadc_delay_timer.sv
// start delay timer: (steps + 1) periods of P_STEP_CYCLES clocks, then a one-cycle expire pulse
// assumes i_start and i_abort come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module lvadc_delay_timer #(
   parameter int unsigned P_STEP_CYCLES = 25000
) (
   input  wire logic                i_clk_sys,
   input  wire logic                i_sys_rst,
   input  wire logic                i_start,
   input  wire logic                i_abort,
   input  wire lvadc_pkg::lvadc_dcode_t i_steps,
   output logic                     o_expire
);
   import lvadc_pkg::*;

   logic [31:0]   cyc_q;
   lvadc_dcode_t  step_q;
   logic          run_q;

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst || i_abort) begin
         cyc_q    <= 32'h0000_0000;
         step_q   <= 5'h00;
         run_q    <= 1'b0;
         o_expire <= 1'b0;
      end else if (i_start) begin
         cyc_q    <= 32'h0000_0000;
         step_q   <= i_steps;
         run_q    <= 1'b1;
         o_expire <= 1'b0;
      end else if (run_q) begin
         o_expire <= 1'b0;
         if (cyc_q == 32'(P_STEP_CYCLES - 1)) begin
            cyc_q <= 32'h0000_0000;
            if (step_q == 5'h00) begin
               run_q    <= 1'b0;
               o_expire <= 1'b1;
            end else begin
               step_q <= step_q - 5'h01;
            end
         end else begin
            cyc_q <= cyc_q + 32'h0000_0001;
         end
      end else begin
         o_expire <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: lvadc_pkg.sv
// types shared by the led voltage converter control
// assumes lvadc_consts.svh is on the include path
package lvadc_pkg;
   typedef logic [3:0] lvadc_code_t;
   typedef logic [4:0] lvadc_dcode_t;

   typedef enum logic [1:0] {
      LVADC_IDLE = 2'b00,
      LVADC_WAIT = 2'b01,
      LVADC_CONV = 2'b10
   } lvadc_state_e;

   // max keeps monotonic order of both channel codes
   function automatic lvadc_code_t lvadc_higher(input lvadc_code_t a, input lvadc_code_t b);
      lvadc_higher = (a > b) ? a : b;
   endfunction
endpackage

// file: testbench.sv
// self-checking bench for the led voltage converter control: registers, delays, flash and manual starts
// assumes lvadc_pkg and lvadc_consts.svh compiled first; bench plays serial slave and converter
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import lvadc_pkg::*;
   localparam int STEP = 4;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic       wr = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic       rd = 1'b0;
   logic [7:0] rdata;
   logic       flash = 1'b0;
   logic       ready = 1'b0;
   lvadc_code_t c1 = 4'h0;
   lvadc_code_t c2 = 4'h0;
   logic       start;
   logic       shdn;
   logic       done;
   logic       rd_pend = 1'b0;
   logic [7:0] exp_q[$];
   logic [3:0] res = 4'h0;
   logic       man = 1'b0;
   int         n_mismatch = 0;
   int         n_tests = 0;
   int         starts = 0;
   int         cyc = 0;

   lvadc_ctrl #(.P_STEP_CYCLES(STEP)) u_dut (
      .i_clk_sys       (clk),
      .i_sys_rst       (rst),
      .i_reg_addr      (addr),
      .i_reg_wr        (wr),
      .i_reg_wdata     (wdata),
      .i_reg_rd        (rd),
      .o_reg_rdata     (rdata),
      .i_flash_pulse   (flash),
      .i_conv_ready    (ready),
      .i_led1_code     (c1),
      .i_led2_code     (c2),
      .o_conv_start    (start),
      .o_conv_shutdown (shdn),
      .o_conv_done     (done)
   );

   always #5 clk = ~clk;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk); #1;
      addr = a; wdata = d; wr = 1'b1;
      @(posedge clk); #1;
      wr = 1'b0;
   endtask

   // expectation noted first, the watcher below pops it when data lands
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge clk); #1;
      addr = a; rd = 1'b1;
      @(posedge clk); #1;
      rd = 1'b0;
   endtask

   // read data is registered: compare one edge after the strobe edge
   always @(posedge clk) begin
      if (rd_pend) chk("rdata", rdata, exp_q.pop_front());
      rd_pend <= rd;
      if (start === 1'b1) starts++;
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic conv(input bit by_flash, input logic [5:0] dly);
      int n;
      int lat;
      logic [3:0] a;
      logic [3:0] b;
      n = 0;
      wreg(8'h31, {2'b00, dly});
      // start is registered on the trigger edge itself when no delay is set
      lat = dly[5] ? 0 : (int'(dly[4:0]) + 1) * STEP + 1;
      if (by_flash) begin
         @(posedge clk); #1;
         flash = 1'b1;
      end else begin
         wreg(8'h30, 8'h10);
         man = 1'b1;
      end
      while (start !== 1'b1 && n < 400) begin
         @(posedge clk); #1;
         n++;
      end
      flash = 1'b0;
      // flash edge passes a synchroniser, so two or three edges of slack
      if (by_flash) chk("flash_lat", (n >= lat + 2 && n <= lat + 3), 1);
      else chk("manual_lat", n, lat);
      rreg(8'h30, {3'b000, man, res});
      a = 4'($urandom);
      b = 4'($urandom);
      c1 = a;
      c2 = b;
      @(posedge clk); #1;
      ready = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      chk("done_pin", done, 1'b1);
      res = (a > b) ? a : b;
      rreg(8'h30, {2'b01, 1'b0, man, res});
      repeat (2) @(posedge clk);
      #1;
      chk("done_clr", done, 1'b0);
      rreg(8'h30, {3'b000, man, res});
      ready = 1'b0;
      repeat (3) @(posedge clk);
   endtask

   initial begin
      int s;
      void'($urandom(32'h5f92));
      repeat (10) @(posedge clk);
      #1;
      rst = 1'b0;
      rreg(8'h30, 8'h00);
      rreg(8'h31, 8'h00);
      rreg(8'h55, 8'h00);
      wreg(8'h31, 8'hFF);
      rreg(8'h31, 8'h3F);
      wreg(8'h55, 8'hAA);
      rreg(8'h55, 8'h00);
      conv(1'b1, 6'h20);
      conv(1'b0, 6'h20);
      conv(1'b0, 6'h00);
      conv(1'b1, 6'h03);
      conv(1'b0, {1'b0, 5'($urandom)});
      conv(1'b1, 6'h1F);
      // shutdown: abort a pending start wait, then flash and manual requests must both be dropped
      wreg(8'h31, 8'h1F);
      wreg(8'h30, 8'h10);
      wreg(8'h30, 8'h20);
      man = 1'b0;
      @(posedge clk); #1;
      chk("shdn_pin", shdn, 1'b1);
      s = starts;
      @(posedge clk); #1;
      flash = 1'b1;
      wreg(8'h30, 8'h30);
      man = 1'b1;
      repeat (150) @(posedge clk);
      #1;
      flash = 1'b0;
      chk("shdn_starts", starts - s, 0);
      rreg(8'h30, {3'b001, man, res});
      wreg(8'h30, 8'h00);
      man = 1'b0;
      @(posedge clk); #1;
      chk("shdn_off", shdn, 1'b0);
      conv(1'b0, 6'h01);
      end_sim();
   end
endmodule
`default_nettype wire
